// ---- dimr_pkg.sv ----
// Shared constants and carriers for the memory init / mode register block.
// Assumes one 200 MHz command clock and a synchronous active-high reset.
package dimr_pkg;

  // Clock period and derived cycle counts
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DLL_LOCK_CYCLES = 20000;
  localparam int PWRDN_GUARD_CYCLES = 10;

  // Mode register field positions (address bits)
  localparam int MR_BL_LSB = 0;
  localparam int MR_RL_LO_POS = 2;
  localparam int MR_BT_POS = 3;
  localparam int MR_RL_HI_LSB = 4;
  localparam int MR_TM_POS = 7;
  localparam int MR_DLLRST_POS = 8;
  localparam int MR_WL_LSB = 9;

  // Reset values of held state
  localparam logic [13:0] MR_RESET_VAL = 14'h0000;
  localparam logic [2:0] SYNC_RESET_VAL = 3'h0;

  // Burst length codes in bits 1:0
  localparam logic [1:0] BL_CODE_4 = 2'h2;
  localparam logic [1:0] BL_CODE_8 = 2'h3;
  localparam logic [2:0] BL_MASK_4 = 3'h3;
  localparam logic [2:0] BL_MASK_8 = 3'h7;

  // Supported latency limits
  localparam logic [3:0] RL_MIN = 4'h4;
  localparam logic [2:0] WL_MIN = 3'h1;

  // Mode register image, laid out exactly as {bank_hi, bank_lo, A11..A0}
  typedef struct packed {
    logic bank_select_hi;
    logic bank_select_lo;
    logic [2:0] write_latency;
    logic dll_reset;
    logic test_mode;
    logic [2:0] read_latency_hi;
    logic burst_type_bit;
    logic read_latency_lo;
    logic [1:0] burst_len;
  } dimr_mode_s;

  // Command pins as sampled on a clock edge
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank_select_hi;
    logic bank_select_lo;
    logic [11:0] addr;
  } dimr_cmd_s;

endpackage

// ---- dimr_lat_pipe.sv ----
// Latency delay line: carries a command token and its column.
// Assumes lat_i stays in 1..DEPTH-1 while tokens are in flight.
module dimr_lat_pipe #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Token in
  input wire logic start_i,
  input wire logic [W-1:0] data_i,
  input wire logic [$clog2(DEPTH)-1:0] lat_i,
  // Tap, due on the next edge
  output logic tap_valid_o,
  output logic [W-1:0] tap_data_o,
  output logic busy_o
);

  logic [DEPTH-1:0] vld_r;
  logic [DEPTH-1:0] vld_nxt;
  logic [W-1:0] dat_r [DEPTH];
  logic [W-1:0] dat_nxt [DEPTH];

  always_comb begin
    vld_nxt = {vld_r[DEPTH-2:0], start_i};
    dat_nxt[0] = data_i;
    for (int i = 1; i < DEPTH; i++) begin
      dat_nxt[i] = dat_r[i-1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vld_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        dat_r[i] <= '0;
      end
    end else begin
      vld_r <= vld_nxt;
      for (int i = 0; i < DEPTH; i++) begin
        dat_r[i] <= dat_nxt[i];
      end
    end
  end

  // Stage lat-1 holds a token taken lat-1 edges ago
  always_comb begin
    tap_valid_o = vld_r[lat_i - 1'b1];
    tap_data_o = dat_r[lat_i - 1'b1];
    busy_o = |vld_r;
  end

endmodule

// ---- dimr_top.sv ----
// Device-side init and mode register logic: command decode, mode register,
// termination strap, impedance update, latency timing and burst ordering.
// Assumes command pins are synchronous to clk_i; the reset pin is not.
//
// How it works
// - Reset pin rising latches clock enable: low gives half, high full termination.
// - All four strobes low loads address 0..11 and bank bits.
// - Fields: burst length, read latency, test, loop reset, write latency.
// - Impedance updates on auto refresh and on no-op without a read.
// - Bursts wrap inside an aligned block of burst length columns.
// - Length four starts at zero; length eight may start at any of its eight columns.
// - Only sequential ordering; an interleave request is flagged.
// - Read at edge n gives first data at edge n plus read latency.
// - Write at edge n expects first data at edge n plus write latency.
// - Loop-reset bit clears when lock ends.
module dimr_top #(
  parameter int COL_W = 8,
  parameter int LOCK_CYCLES = dimr_pkg::DLL_LOCK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Device pins
  input wire logic device_reset_pin_i,
  input wire logic cke_i,
  input wire dimr_pkg::dimr_cmd_s cmd_i,
  // Mode and extended mode state
  output dimr_pkg::dimr_mode_s mode_o,
  output dimr_pkg::dimr_mode_s ext_mode_o,
  output logic dll_locked_o,
  output logic addr_term_half_o,
  output logic burst_type_err_o,
  // Impedance update strobe
  output logic zq_update_o,
  // Burst column streams
  output logic rd_valid_o,
  output logic [COL_W-1:0] rd_col_o,
  output logic wr_valid_o,
  output logic [COL_W-1:0] wr_col_o
);

  localparam int CW = $clog2(LOCK_CYCLES + 1);

  // Reset pin synchroniser, three stages
  logic [2:0] rsync_r;
  logic [2:0] rsync_nxt;
  logic pin_lvl_r;
  logic pin_lvl_nxt;

  // Control state
  dimr_pkg::dimr_mode_s mode_r, mode_nxt;
  dimr_pkg::dimr_mode_s ext_r, ext_nxt;
  logic [CW-1:0] lock_cnt_r, lock_cnt_nxt;
  logic locked_r, locked_nxt;
  logic term_half_r, term_half_nxt;
  logic bt_err_r, bt_err_nxt;
  logic zq_r, zq_nxt;

  // Command decode
  logic live;
  logic is_mw;
  logic is_rd;
  logic is_wr;
  logic is_ref;
  logic is_nop;
  logic [3:0] rl_eff;
  logic [3:0] wl_eff;

  // Latency pipes and burst engines, index 0 read, 1 write
  logic tap_v [2];
  logic [COL_W-1:0] tap_d [2];
  logic busy [2];
  logic start [2];
  logic [3:0] lat [2];
  logic act_r [2], act_nxt [2];
  logic [2:0] rem_r [2], rem_nxt [2];
  logic [2:0] off_r [2], off_nxt [2];
  logic [2:0] msk_r [2], msk_nxt [2];
  logic [COL_W-1:0] base_r [2], base_nxt [2];
  logic [COL_W-1:0] col_r [2], col_nxt [2];

  always_comb begin
    // Change counts once stages two and three agree
    rsync_nxt = {rsync_r[1:0], device_reset_pin_i};
    pin_lvl_nxt = (rsync_r[2] == rsync_r[1]) ? rsync_r[2] : pin_lvl_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsync_r <= dimr_pkg::SYNC_RESET_VAL;
      pin_lvl_r <= 1'b0;
    end else begin
      rsync_r <= rsync_nxt;
      pin_lvl_r <= pin_lvl_nxt;
    end
  end

  always_comb begin
    // Commands are ignored while the reset pin holds the device down
    live = pin_lvl_r && cke_i && !cmd_i.cs_n;
    is_mw = live && !cmd_i.ras_n && !cmd_i.cas_n && !cmd_i.we_n;
    is_ref = live && !cmd_i.ras_n && !cmd_i.cas_n && cmd_i.we_n;
    is_rd = live && cmd_i.ras_n && !cmd_i.cas_n && cmd_i.we_n;
    is_wr = live && cmd_i.ras_n && !cmd_i.cas_n && !cmd_i.we_n;
    is_nop = pin_lvl_r && (cmd_i.cs_n || (cmd_i.ras_n && cmd_i.cas_n && cmd_i.we_n));
    // Out-of-range codes clamp to the shortest legal latency
    rl_eff = {mode_r.read_latency_lo, mode_r.read_latency_hi};
    if (rl_eff < dimr_pkg::RL_MIN) begin
      rl_eff = dimr_pkg::RL_MIN;
    end
    wl_eff = {1'b0, mode_r.write_latency};
    if (mode_r.write_latency < dimr_pkg::WL_MIN) begin
      wl_eff = {1'b0, dimr_pkg::WL_MIN};
    end
  end

  always_comb begin
    mode_nxt = mode_r;
    ext_nxt = ext_r;
    lock_cnt_nxt = lock_cnt_r;
    locked_nxt = locked_r;
    term_half_nxt = term_half_r;
    bt_err_nxt = bt_err_r;
    // Strap caught on the filtered rising edge of the reset pin
    if (pin_lvl_nxt && !pin_lvl_r) begin
      term_half_nxt = !cke_i;
    end
    if (lock_cnt_r != '0) begin
      lock_cnt_nxt = lock_cnt_r - 1'b1;
      if (lock_cnt_r == CW'(1)) begin
        locked_nxt = 1'b1;
        mode_nxt.dll_reset = 1'b0;
      end
    end
    if (is_mw) begin
      if (!cmd_i.bank_select_lo) begin
        mode_nxt = dimr_pkg::dimr_mode_s'({cmd_i.bank_select_hi, cmd_i.bank_select_lo,
                                           cmd_i.addr});
        bt_err_nxt = cmd_i.addr[dimr_pkg::MR_BT_POS];
        if (cmd_i.addr[dimr_pkg::MR_DLLRST_POS]) begin
          lock_cnt_nxt = CW'(LOCK_CYCLES);
          locked_nxt = 1'b0;
        end
      end else begin
        ext_nxt = dimr_pkg::dimr_mode_s'({cmd_i.bank_select_hi, cmd_i.bank_select_lo,
                                          cmd_i.addr});
      end
    end
    // Calibration runs in the gaps; it is invisible to timing
    zq_nxt = is_ref || (is_nop && !busy[0] && !act_r[0]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= dimr_pkg::MR_RESET_VAL;
      ext_r <= dimr_pkg::MR_RESET_VAL;
      lock_cnt_r <= '0;
      locked_r <= 1'b0;
      term_half_r <= 1'b0;
      bt_err_r <= 1'b0;
      zq_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      ext_r <= ext_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      locked_r <= locked_nxt;
      term_half_r <= term_half_nxt;
      bt_err_r <= bt_err_nxt;
      zq_r <= zq_nxt;
    end
  end

  always_comb begin
    start[0] = is_rd;
    start[1] = is_wr;
    lat[0] = rl_eff;
    lat[1] = wl_eff;
  end

  for (genvar k = 0; k < 2; k++) begin : g_chan
    dimr_lat_pipe #(
      .W(COL_W),
      .DEPTH(16)
    ) u_pipe (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(start[k]),
      .data_i(cmd_i.addr[COL_W-1:0]),
      .lat_i(lat[k]),
      .tap_valid_o(tap_v[k]),
      .tap_data_o(tap_d[k]),
      .busy_o(busy[k])
    );

    always_comb begin
      act_nxt[k] = 1'b0;
      rem_nxt[k] = rem_r[k];
      off_nxt[k] = off_r[k];
      msk_nxt[k] = msk_r[k];
      base_nxt[k] = base_r[k];
      col_nxt[k] = col_r[k];
      if (tap_v[k]) begin
        // Beat 0 lands on edge n+m; later beats follow one per clock
        msk_nxt[k] = (mode_r.burst_len == dimr_pkg::BL_CODE_8) ?
                     dimr_pkg::BL_MASK_8 : dimr_pkg::BL_MASK_4;
        base_nxt[k] = tap_d[k] & ~COL_W'(msk_nxt[k]);
        // Length four always starts at the block start
        off_nxt[k] = (msk_nxt[k] == dimr_pkg::BL_MASK_4) ? 3'h0 :
                     tap_d[k][2:0];
        rem_nxt[k] = msk_nxt[k];
        act_nxt[k] = 1'b1;
        col_nxt[k] = base_nxt[k] | COL_W'(off_nxt[k]);
      end else if (rem_r[k] != 3'h0) begin
        off_nxt[k] = (off_r[k] + 3'h1) & msk_r[k];
        rem_nxt[k] = rem_r[k] - 3'h1;
        act_nxt[k] = 1'b1;
        col_nxt[k] = base_r[k] | COL_W'(off_nxt[k]);
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        act_r[k] <= 1'b0;
        rem_r[k] <= 3'h0;
        off_r[k] <= 3'h0;
        msk_r[k] <= 3'h0;
        base_r[k] <= '0;
        col_r[k] <= '0;
      end else begin
        act_r[k] <= act_nxt[k];
        rem_r[k] <= rem_nxt[k];
        off_r[k] <= off_nxt[k];
        msk_r[k] <= msk_nxt[k];
        base_r[k] <= base_nxt[k];
        col_r[k] <= col_nxt[k];
      end
    end
  end

  always_comb begin
    mode_o = mode_r;
    ext_mode_o = ext_r;
    dll_locked_o = locked_r;
    addr_term_half_o = term_half_r;
    burst_type_err_o = bt_err_r;
    zq_update_o = zq_r;
    rd_valid_o = act_r[0];
    rd_col_o = col_r[0];
    wr_valid_o = act_r[1];
    wr_col_o = col_r[1];
  end

endmodule

// ---- dimr_top_props.sv ----
// Checker for dimr_top, bound to every instance.
// Assumes the reset pin stays clean once raised; sees top ports only.
module dimr_top_chk #(
  parameter int COL_W = 8,
  parameter int LOCK_CYCLES = 16
) (
  // Clock, reset and pins
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic device_reset_pin_i,
  input wire logic cke_i,
  input wire dimr_pkg::dimr_cmd_s cmd_i,
  // Outputs watched
  input wire dimr_pkg::dimr_mode_s mode_o,
  input wire dimr_pkg::dimr_mode_s ext_mode_o,
  input wire logic dll_locked_o,
  input wire logic addr_term_half_o,
  input wire logic burst_type_err_o,
  input wire logic zq_update_o,
  input wire logic rd_valid_o,
  input wire logic [COL_W-1:0] rd_col_o,
  input wire logic wr_valid_o,
  input wire logic [COL_W-1:0] wr_col_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LK = LOCK_CYCLES + 1;
  logic [2:0] pin_r, pin_nxt;
  logic [4:0] rc_r, rc_nxt, wc_r, wc_nxt, rl, wl;
  logic live, mw, rd, wr;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Count of pin-high samples mirrors the filter delay
  always_comb begin
    live = device_reset_pin_i && pin_r == 3'h4 && cke_i && !cmd_i.cs_n;
    mw = live && !cmd_i.ras_n && !cmd_i.cas_n && !cmd_i.we_n;
    rd = live && cmd_i.ras_n && !cmd_i.cas_n && cmd_i.we_n;
    wr = live && cmd_i.ras_n && !cmd_i.cas_n && !cmd_i.we_n;
    rl = {1'b0, mode_o.read_latency_lo, mode_o.read_latency_hi};
    rl = (rl < 5'h4) ? 5'h4 : rl;
    wl = {2'h0, mode_o.write_latency};
    wl = (wl == 5'h0) ? 5'h1 : wl;
    pin_nxt = (rst_i || !device_reset_pin_i) ? 3'h0 : (pin_r == 3'h4 ? pin_r : pin_r + 3'h1);
    // Restart only once the previous first beat is due, so a seamless chain is timed
    // from its first command rather than from the newest one
    rc_nxt = rst_i ? 5'h1f : ((rd && rc_r > rl) ? 5'h1 : (rc_r == 5'h1f ? rc_r : rc_r + 5'h1));
    wc_nxt = rst_i ? 5'h1f : ((wr && wc_r > wl) ? 5'h1 : (wc_r == 5'h1f ? wc_r : wc_r + 5'h1));
  end
  always_ff @(posedge clk_i) begin
    pin_r <= pin_nxt;
    rc_r <= rc_nxt;
    wc_r <= wc_nxt;
  end
  chk_mode_load: assert property (
    mw && !cmd_i.bank_select_lo |=>
    mode_o == {$past(cmd_i.bank_select_hi), 1'b0, $past(cmd_i.addr)})
    else $error("mode register load wrong");
  chk_ext_load: assert property (
    mw && cmd_i.bank_select_lo |=>
    ext_mode_o == {$past(cmd_i.bank_select_hi), 1'b1, $past(cmd_i.addr)})
    else $error("extended mode load wrong");
  chk_lock_drop: assert property (
    mw && !cmd_i.bank_select_lo && cmd_i.addr[8] |=> !dll_locked_o && mode_o.dll_reset)
    else $error("loop reset not started");
  chk_lock_done: assert property (
    mw && !cmd_i.bank_select_lo && cmd_i.addr[8] |-> ##LK dll_locked_o && !mode_o.dll_reset)
    else $error("loop lock not reached in time");
  chk_term_strap: assert property (
    pin_r == 3'h3 && device_reset_pin_i |=> addr_term_half_o == !$past(cke_i))
    else $error("termination strap wrong");
  chk_zq_refresh: assert property (
    live && !cmd_i.ras_n && !cmd_i.cas_n && cmd_i.we_n |=> zq_update_o)
    else $error("no impedance update on refresh");
  chk_bt_flag: assert property (
    mw && !cmd_i.bank_select_lo |=> burst_type_err_o == $past(cmd_i.addr[3]))
    else $error("burst type flag wrong");
  chk_rd_first: assert property (
    $rose(rd_valid_o) |-> rc_r == rl + 5'h1)
    else $error("read data at wrong edge");
  chk_wr_first: assert property (
    $rose(wr_valid_o) |-> wc_r == wl + 5'h1)
    else $error("write data at wrong edge");
  chk_bl4_start: assert property (
    $rose(rd_valid_o) && mode_o.burst_len != dimr_pkg::BL_CODE_8 |-> rd_col_o[1:0] == 2'h0)
    else $error("length four burst not aligned");
  chk_burst_min: assert property (
    $rose(rd_valid_o) |-> rd_valid_o [*4])
    else $error("read burst too short");
endmodule

bind dimr_top dimr_top_chk #(.COL_W(COL_W), .LOCK_CYCLES(LOCK_CYCLES)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .device_reset_pin_i(device_reset_pin_i), .cke_i(cke_i),
  .cmd_i(cmd_i), .mode_o(mode_o), .ext_mode_o(ext_mode_o), .dll_locked_o(dll_locked_o),
  .addr_term_half_o(addr_term_half_o), .burst_type_err_o(burst_type_err_o),
  .zq_update_o(zq_update_o), .rd_valid_o(rd_valid_o), .rd_col_o(rd_col_o),
  .wr_valid_o(wr_valid_o), .wr_col_o(wr_col_o));

// ---- dimr_ctrl_model.sv ----
// Memory controller model: drives reset pin, clock enable and commands.
// Assumes a free-running clk_i; PWR cycles stand in for the long power waits.
module dimr_ctrl_model #(
  parameter int PWR = 40,
  parameter int LOCK = 16,
  parameter int MRD = 4
) (
  // Clock
  input wire logic clk_i,
  // Pins driven
  output logic device_reset_pin_o,
  output logic cke_o,
  output dimr_pkg::dimr_cmd_s cmd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    device_reset_pin_o = 1'b0;
    cke_o = 1'b0;
    cmd_o = {4'hf, 2'h0, 12'h000};
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Address inverted after a command: no stale value for free
  task automatic send(input logic [3:0] op, input logic [1:0] ba, input logic [11:0] a);
    @(posedge clk_i);
    #1 cmd_o = {op, ba, a};
    @(posedge clk_i);
    #1 cmd_o = {4'h7, ~ba, ~a};
  endtask
  task automatic power_up(input logic strap, input logic [11:0] m);
    device_reset_pin_o = 1'b0;
    cke_o = 1'b0;
    cmd_o = {4'hf, 2'h0, 12'h000};
    idle(PWR);
    idle(PWR);
    #1 cmd_o = {4'h7, 2'h0, 12'h000};
    @(posedge clk_i);
    #1 device_reset_pin_o = 1'b1;
    cke_o = strap;
    idle(4);
    #1 cke_o = 1'b1;
    send(4'h2, 2'h0, 12'h400);
    send(4'h0, 2'h1, 12'h000);
    idle(MRD);
    send(4'h0, 2'h0, m);
    idle(LOCK + 2);
    send(4'h2, 2'h0, 12'h400);
    send(4'h1, 2'h0, 12'h000);
    send(4'h1, 2'h0, 12'h000);
  endtask
endmodule

// ---- dimr_top_test.sv ----
// Testbench for dimr_top: controller model drives pins, queues hold bursts.
// Assumes the checker and controller model are compiled before this file.
module dimr_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LOCK = 16;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pin, cke, lock, half, bterr, zq, rdv, wrv;
  logic [7:0] rdc, wrc;
  logic [7:0] rq[$], wq[$];
  dimr_pkg::dimr_cmd_s cmd;
  dimr_pkg::dimr_mode_s mode, ext;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2.5 clk_i = ~clk_i;
  dimr_top #(.LOCK_CYCLES(LOCK)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .device_reset_pin_i(pin), .cke_i(cke), .cmd_i(cmd), .mode_o(mode), .ext_mode_o(ext),
    .dll_locked_o(lock), .addr_term_half_o(half), .burst_type_err_o(bterr),
    .zq_update_o(zq), .rd_valid_o(rdv), .rd_col_o(rdc), .wr_valid_o(wrv), .wr_col_o(wrc));
  dimr_ctrl_model #(.LOCK(LOCK)) i_ctl (.clk_i(clk_i), .device_reset_pin_o(pin),
    .cke_o(cke), .cmd_o(cmd));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Note the sequential beats, then issue the read or write
  task automatic burst(input logic [7:0] col, input logic w, input logic bl8);
    logic [7:0] e;
    for (int i = 0; i < (bl8 ? 8 : 4); i++) begin
      e = bl8 ? {col[7:3], 3'(col[2:0] + i)} : {col[7:2], 2'(i)};
      if (w) wq.push_back(e);
      else rq.push_back(e);
    end
    i_ctl.send(w ? 4'h4 : 4'h5, 2'h0, {4'h0, col});
  endtask
  // Seamless runs: spacing equals burst length
  task automatic run(input logic bl8);
    for (int w = 0; w < 2; w++) begin
      for (int k = 0; k < 4; k++) begin
        burst(k == 0 ? 8'h14 : 8'($urandom) & (bl8 ? 8'hff : 8'hfc), w[0], bl8);
        i_ctl.idle(bl8 ? 6 : 2);
        #1 if (bl8) check(zq, {15'h0, w[0]});
      end
      i_ctl.idle(24);
    end
  endtask
  always @(negedge clk_i) begin
    if (rdv === 1'b1) begin
      if (rq.size() == 0) check(16'h1, 16'h0);
      else check(rdc, rq.pop_front());
    end
    if (wrv === 1'b1) begin
      if (wq.size() == 0) check(16'h1, 16'h0);
      else check(wrc, wq.pop_front());
    end
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    logic [31:0] seed;
    seed = $urandom(32'h8f0a);
    for (int s = 0; s < 2; s++) begin
      #1 rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #1 rst_i = 1'b0;
      // Read latency 5, length 8, write latency 2, loop reset
      i_ctl.power_up(s[0], 12'h553);
      check(half, {15'h0, !s[0]});
      check(ext, 16'h1000);
      check(mode, 16'h0453);
      check(lock, 16'h1);
      check(zq, 16'h1);
      check(bterr, 16'h0);
      run(1'b1);
      // All banks idle; latency 15, length 4, write latency 7, interleave
      i_ctl.send(4'h0, 2'h0, 12'he7e);
      i_ctl.idle(4);
      #1 check(mode, 16'h0e7e);
      check(bterr, 16'h1);
      run(1'b0);
      $display("test %0d done", s);
    end
    check(16'(rq.size() + wq.size()), 16'h0);
    give_verdict();
  end
endmodule
